//--- design/mmpwm_pkg.sv
package mmpwm_pkg;
  localparam int COUNT_W = 16;
  localparam int PRESC_W = 8;
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_SET_MATCH = 2'h1;
  localparam logic [1:0] MODE_TOGGLE = 2'h2;
  localparam logic [1:0] MODE_CENTER = 2'h3;
  localparam logic [1:0] OFS_NONE = 2'h0;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam int SYNC_STAGES = 3;
endpackage : mmpwm_pkg

//--- design/mmpwm_sync.sv
module mmpwm_sync (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  typedef struct packed {
    logic [mmpwm_pkg::SYNC_STAGES-1:0] sh;
    logic lvl;
  } mmpwm_sync_type;
  mmpwm_sync_type st_r;
  mmpwm_sync_type st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.sh = {st_r.sh[mmpwm_pkg::SYNC_STAGES-2:0], async_i};
    // Only stages two and three vote; stage one feeds nothing else
    if (st_r.sh[mmpwm_pkg::SYNC_STAGES-2] == st_r.sh[mmpwm_pkg::SYNC_STAGES-1]) begin
      st_nxt.lvl = st_r.sh[mmpwm_pkg::SYNC_STAGES-1];
    end
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level_o = st_r.lvl;
  assign rise_o = st_nxt.lvl & ~st_r.lvl;
endmodule : mmpwm_sync

//--- design/mmpwm_core.sv
// Behaviour
// R1: Standard: active at phase, inactive at duty
// R2: Standard: period match restarts the timer
// R3: Standard period is (period+1)*(prescale+1) clocks
// R4: Standard active span is duty minus phase
// R5: Offset match may resynchronise the timer
// R6: Set-match: set at phase, hold until cleared
// R7: Set-match: duty ignored, period bounds timer
// R8: Set-match: level writes apply next tick
// R9: Toggle: 50% duty, twice standard period
// R10: Toggle: phase sets toggle delay after period
// R11: Toggle: level writes do not matter
// R12: Center: timer counts up then down to 0
// R13: Center: set counting up, clear counting down
// R14: Center: up match period-duty, down plus one
// R15: Center period is twice standard period
// R16: Center active span is twice duty
// R17: Center: level writes do not matter
// R18: Timer advances once per prescaled tick
module mmpwm_core #(
  parameter int COUNT_W = mmpwm_pkg::COUNT_W,
  parameter int PRESC_W = mmpwm_pkg::PRESC_W
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic [1:0] mode_i,
  input wire logic [PRESC_W-1:0] prescale_i,
  input wire logic [COUNT_W-1:0] period_count_i,
  input wire logic [COUNT_W-1:0] duty_count_i,
  input wire logic [COUNT_W-1:0] phase_count_i,
  input wire logic level_force_field_i,
  input wire logic level_write_i,
  input wire logic [1:0] offset_mode_i,
  input wire logic offset_event_i,
  output logic pwm_o,
  output logic [COUNT_W-1:0] pwm_timer_count_o,
  output logic period_event_o,
  output logic counting_down_o
);
  if (COUNT_W < 2 || COUNT_W > 32 || PRESC_W < 1 || PRESC_W > 16) begin : g_bad_width
    $error("mmpwm_core: unsupported width");
  end

  typedef struct packed {
    logic [PRESC_W-1:0] pre;
    logic [COUNT_W-1:0] tmr;
    logic down;
    logic out;
    logic tog_wait;
    logic pend_valid;
    logic pend_level;
    logic per_evt;
  } mmpwm_core_type;

  mmpwm_core_type st_r;
  mmpwm_core_type st_nxt;
  logic ofs_rise;
  logic tick;
  logic [COUNT_W-1:0] up_match;
  logic [COUNT_W-1:0] dn_match;

  // Offset event arrives from another block's pin domain
  mmpwm_sync u_ofs_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(offset_event_i),
    .level_o(),
    .rise_o(ofs_rise)
  );

  assign tick = (st_r.pre == prescale_i); // R18
  assign up_match = period_count_i - duty_count_i; // R14
  assign dn_match = up_match + {{(COUNT_W-1){1'b0}}, 1'b1}; // R14

  always_comb begin
    st_nxt = st_r;
    st_nxt.per_evt = 1'b0;
    if (!enable_i) begin
      st_nxt.pre = mmpwm_pkg::PRESC_RESET;
      st_nxt.tmr = mmpwm_pkg::COUNT_RESET;
      st_nxt.down = 1'b0;
      st_nxt.out = 1'b0; // R6
      st_nxt.tog_wait = 1'b0;
      st_nxt.pend_valid = 1'b0;
    end else if (tick) begin
      st_nxt.pre = mmpwm_pkg::PRESC_RESET;
      st_nxt.tmr = st_r.tmr + {{(COUNT_W-1){1'b0}}, 1'b1}; // R18
      case (mode_i)
        mmpwm_pkg::MODE_STANDARD: begin
          if (st_r.tmr == phase_count_i) begin
            st_nxt.out = 1'b1; // R1 R4
          end
          if (st_r.tmr == duty_count_i) begin
            st_nxt.out = 1'b0; // R1 R4
          end
          if (st_r.tmr >= period_count_i) begin
            st_nxt.tmr = mmpwm_pkg::COUNT_RESET; // R2 R3
            st_nxt.per_evt = 1'b1;
          end
        end
        mmpwm_pkg::MODE_SET_MATCH: begin
          if (st_r.tmr == phase_count_i && phase_count_i <= period_count_i) begin
            st_nxt.out = 1'b1; // R6 R7
          end
          if (st_r.pend_valid) begin
            st_nxt.out = st_r.pend_level; // R8
            st_nxt.pend_valid = 1'b0;
          end
          if (st_r.tmr >= period_count_i) begin
            st_nxt.tmr = mmpwm_pkg::COUNT_RESET; // R7
            st_nxt.per_evt = 1'b1;
          end
        end
        mmpwm_pkg::MODE_TOGGLE: begin
          // Duty and level writes are ignored here
          if (st_r.tog_wait && st_r.tmr == phase_count_i) begin
            st_nxt.out = ~st_r.out; // R9 R10 R11
            st_nxt.tog_wait = 1'b0;
          end
          if (st_r.tmr >= period_count_i) begin
            st_nxt.tmr = mmpwm_pkg::COUNT_RESET;
            st_nxt.per_evt = 1'b1;
            st_nxt.tog_wait = 1'b1; // R10
          end
        end
        default: begin
          if (!st_r.down) begin
            if (st_r.tmr == up_match) begin
              st_nxt.out = 1'b1; // R13 R16 R17
            end
            if (st_r.tmr >= period_count_i) begin
              // The peak stands for two ticks so one period spans 2*(period+1) ticks
              st_nxt.down = 1'b1; // R12 R15
              st_nxt.tmr = st_r.tmr;
            end
          end else begin
            st_nxt.tmr = st_r.tmr - {{(COUNT_W-1){1'b0}}, 1'b1};
            if (st_r.tmr == dn_match) begin
              st_nxt.out = 1'b0; // R13 R14
            end
            if (st_r.tmr == mmpwm_pkg::COUNT_RESET) begin
              st_nxt.down = 1'b0; // R12
              st_nxt.tmr = mmpwm_pkg::COUNT_RESET;
              st_nxt.per_evt = 1'b1;
            end
          end
        end
      endcase
    end else begin
      st_nxt.pre = st_r.pre + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
    // Offset sync restarts the period; the detailed offset modes live elsewhere
    if (enable_i && offset_mode_i != mmpwm_pkg::OFS_NONE && ofs_rise) begin
      st_nxt.tmr = mmpwm_pkg::COUNT_RESET; // R5
      st_nxt.pre = mmpwm_pkg::PRESC_RESET;
      st_nxt.down = 1'b0;
    end
    // A level write is held until the next tick, so it lands on a PWM clock edge.
    // Captured last so a write on the tick that drains the previous one is kept.
    if (enable_i && level_write_i && mode_i == mmpwm_pkg::MODE_SET_MATCH) begin
      st_nxt.pend_valid = 1'b1; // R8
      st_nxt.pend_level = level_force_field_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm_o = st_r.out;
  assign pwm_timer_count_o = st_r.tmr;
  assign period_event_o = st_r.per_evt;
  assign counting_down_o = st_r.down;

  chk_disable_clears: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !enable_i |=> !pwm_o) else $error("output active while disabled");
  chk_std_period_wrap: assert property ( // R2
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_STANDARD && !ofs_rise
    && st_r.tmr >= period_count_i |=> pwm_timer_count_o == '0)
    else $error("standard timer did not wrap");
  chk_std_phase_set: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_STANDARD
    && st_r.tmr == phase_count_i && st_r.tmr != duty_count_i |=> pwm_o)
    else $error("standard phase match missed");
  chk_std_duty_clear: assert property ( // R1
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_STANDARD
    && st_r.tmr == duty_count_i |=> !pwm_o) else $error("standard duty match missed");
  chk_timer_hold: assert property ( // R18
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && !tick && !ofs_rise |=> $stable(pwm_timer_count_o))
    else $error("timer moved without tick");
  chk_setm_hold: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && mode_i == mmpwm_pkg::MODE_SET_MATCH && pwm_o && !st_r.pend_valid
    && !level_write_i && $stable(mode_i) |=> pwm_o) else $error("set-match output dropped");
  chk_setm_phase_set: assert property ( // R6
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_SET_MATCH && !st_r.pend_valid
    && st_r.tmr == phase_count_i && phase_count_i <= period_count_i |=> pwm_o)
    else $error("set-match phase match missed");
  // A phase beyond the period can never be reached, so the output must stay low
  chk_setm_far_phase: assert property ( // R7
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && mode_i == mmpwm_pkg::MODE_SET_MATCH && !pwm_o && !st_r.pend_valid
    && phase_count_i > period_count_i |=> !pwm_o)
    else $error("set-match matched above period");
  chk_setm_write: assert property ( // R8
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_SET_MATCH && st_r.pend_valid
    && !(st_r.tmr == phase_count_i && phase_count_i <= period_count_i)
    |=> pwm_o == $past(st_r.pend_level)) else $error("level write not applied");
  chk_toggle_flip: assert property ( // R10
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_TOGGLE && st_r.tog_wait
    && st_r.tmr == phase_count_i |=> pwm_o != $past(pwm_o))
    else $error("toggle at phase missed");
  chk_toggle_nowrite: assert property ( // R11
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && !tick && mode_i == mmpwm_pkg::MODE_TOGGLE && $stable(mode_i)
    |=> $stable(pwm_o)) else $error("toggle output changed off tick");
  chk_center_up_set: assert property ( // R13
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_CENTER && !st_r.down
    && st_r.tmr == up_match |=> pwm_o) else $error("center set missed");
  chk_center_down: assert property ( // R13
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_CENTER && st_r.down
    && st_r.tmr == dn_match && !ofs_rise |=> !pwm_o) else $error("center clear missed");
  chk_center_peak: assert property ( // R15
    @(posedge sys_clk_i) disable iff (!nrst_i)
    enable_i && tick && mode_i == mmpwm_pkg::MODE_CENTER && !st_r.down && !ofs_rise
    && st_r.tmr >= period_count_i |=> counting_down_o
    && pwm_timer_count_o == $past(pwm_timer_count_o)) else $error("center peak not held");
endmodule : mmpwm_core

//--- testbench/mmpwm_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, nrst_i, enable_i, level_force_field_i, level_write_i, offset_event_i;
  logic [1:0] mode_i, offset_mode_i;
  logic [7:0] prescale_i;
  logic [15:0] period_count_i, duty_count_i, phase_count_i, pwm_timer_count_o;
  logic pwm_o, period_event_o, counting_down_o;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hi;
  int ev;
  int dn;
  logic last;

  mmpwm_core u_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .mode_i(mode_i),
    .prescale_i(prescale_i), .period_count_i(period_count_i), .duty_count_i(duty_count_i),
    .phase_count_i(phase_count_i), .level_force_field_i(level_force_field_i),
    .level_write_i(level_write_i), .offset_mode_i(offset_mode_i),
    .offset_event_i(offset_event_i), .pwm_o(pwm_o), .pwm_timer_count_o(pwm_timer_count_o),
    .period_event_o(period_event_o), .counting_down_o(counting_down_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Runs are short; this ceiling only catches a hung wait
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  // Disable first so every mode starts from a cleared timer
  task setup(input logic [1:0] m, input logic [7:0] ps, input logic [15:0] pr, dc, ph);
    tick(1);
    enable_i = 1'b0;
    mode_i = m;
    prescale_i = ps;
    period_count_i = pr;
    duty_count_i = dc;
    phase_count_i = ph;
    tick(1);
    enable_i = 1'b1;
  endtask : setup

  task lvl(input logic v);
    level_force_field_i = v;
    level_write_i = 1'b1;
    tick(1);
    level_write_i = 1'b0;
  endtask : lvl

  // Aligns to a period event, then counts whole periods so phase does not matter
  task measure(input int n);
    int k;
    hi = 0;
    ev = 0;
    dn = 0;
    for (k = 0; k < 2000 && period_event_o !== 1'b1; k++) tick(1);
    for (k = 0; k < n; k++) begin
      tick(1);
      hi += (pwm_o === 1'b1);
      ev += (period_event_o === 1'b1);
      dn += (counting_down_o === 1'b1);
    end
  endtask : measure

  initial begin
    nrst_i = 1'b0;
    enable_i = 1'b0;
    mode_i = 2'h0;
    prescale_i = 8'h00;
    period_count_i = 16'h0000;
    duty_count_i = 16'h0000;
    phase_count_i = 16'h0000;
    level_force_field_i = 1'b0;
    level_write_i = 1'b0;
    offset_mode_i = 2'h0;
    offset_event_i = 1'b0;
    tick(12);
    nrst_i = 1'b1;
    setup(mmpwm_pkg::MODE_STANDARD, 8'h01, 16'h0004, 16'h0003, 16'h0001);
    measure(30);
    check(16'(ev), 16'h0003);
    check(16'(hi), 16'h000C);
    level_write_i = 1'b1;
    level_force_field_i = 1'b1;
    setup(mmpwm_pkg::MODE_TOGGLE, 8'h01, 16'h0004, 16'h0003, 16'h0002);
    measure(40);
    check(16'(ev), 16'h0004);
    check(16'(hi), 16'h0014);
    // The toggle edge lands one count past the phase value
    last = pwm_o;
    for (hi = 0; hi < 40 && pwm_o === last; hi++) tick(1);
    check(pwm_timer_count_o, 16'h0003);
    setup(mmpwm_pkg::MODE_CENTER, 8'h00, 16'h0004, 16'h0002, 16'h0000);
    measure(30);
    check(16'(ev), 16'h0003);
    check(16'(hi), 16'h000C);
    check(16'(dn), 16'h000F);
    level_write_i = 1'b0;
    setup(mmpwm_pkg::MODE_SET_MATCH, 8'h00, 16'h0004, 16'h0001, 16'h0007);
    tick(30);
    check(16'(pwm_o), 16'h0000);
    lvl(1'b1);
    tick(1);
    check(16'(pwm_o), 16'h0001);
    tick(20);
    check(16'(pwm_o), 16'h0001);
    lvl(1'b0);
    tick(1);
    check(16'(pwm_o), 16'h0000);
    setup(mmpwm_pkg::MODE_SET_MATCH, 8'h00, 16'h0004, 16'h0001, 16'h0002);
    tick(12);
    check(16'(pwm_o), 16'h0001);
    enable_i = 1'b0;
    tick(2);
    check(16'(pwm_o), 16'h0000);
    offset_mode_i = 2'h1;
    setup(mmpwm_pkg::MODE_STANDARD, 8'h00, 16'h0064, 16'h0002, 16'h0001);
    tick(50);
    offset_event_i = 1'b1;
    tick(8);
    check(16'(pwm_timer_count_o < 16'h0008), 16'h0001);
    offset_event_i = 1'b0;
    close_out();
  end
endmodule : testbench
